// ---- core/adcdc_core.sv ----
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "adcdc_cfg.svh"

module adcdc_core #(
    parameter int NUM_COMP = 8
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     res_valid,
    input  wire adcdc_pkg::adcdc_result_t res_data,
    output logic      [NUM_COMP-1:0]      fault_trigger,
    output logic      [`ADCDC_NUM_SEQ-1:0] compare_irq_seq,
    output logic                          irq
);
    import adcdc_pkg::*;

    // ****************************************************************
    // Band and mode decoding
    // ****************************************************************
    function automatic adcdc_region_t classify(logic [`ADCDC_DATA_W-1:0] v, adcdc_thr_t t);
        if (v <= t.lower_threshold) begin
            return REG_LOW;
        end else if (v <= t.upper_threshold) begin
            return REG_MID;
        end
        return REG_HIGH;
    endfunction

    function automatic adcdc_region_t mode_target(adcdc_mode_t m);
        case (m)
            `ADCDC_M_LOW_EACH, `ADCDC_M_LOW_ENTRY,
            `ADCDC_M_LOW_EACH_H, `ADCDC_M_LOW_ENTRY_H: begin
                return REG_LOW;
            end
            `ADCDC_M_MID_EACH, `ADCDC_M_MID_ENTRY: begin
                return REG_MID;
            end
            `ADCDC_M_HIGH_EACH, `ADCDC_M_HIGH_ENTRY,
            `ADCDC_M_HIGH_EACH_H, `ADCDC_M_HIGH_ENTRY_H: begin
                return REG_HIGH;
            end
            default: begin
                return REG_NONE;
            end
        endcase
    endfunction

    function automatic logic mode_entry(adcdc_mode_t m);
        return (m == `ADCDC_M_LOW_ENTRY) || (m == `ADCDC_M_LOW_ENTRY_H) ||
               (m == `ADCDC_M_MID_ENTRY) || (m == `ADCDC_M_HIGH_ENTRY) ||
               (m == `ADCDC_M_HIGH_ENTRY_H);
    endfunction

    // Mid band has no hysteresis code at all, so it can never arm
    function automatic logic mode_hyst(adcdc_mode_t m);
        return (m == `ADCDC_M_LOW_EACH_H) || (m == `ADCDC_M_LOW_ENTRY_H) ||
               (m == `ADCDC_M_HIGH_EACH_H) || (m == `ADCDC_M_HIGH_ENTRY_H);
    endfunction

    function automatic adcdc_region_t mode_opposite(adcdc_mode_t m);
        if (!mode_hyst(m)) begin
            return REG_NONE;
        end
        return (mode_target(m) == REG_LOW) ? REG_HIGH : REG_LOW;
    endfunction

    // Off and unused codes decode to no target band and never fire
    function automatic logic mode_fires(adcdc_mode_t m, adcdc_region_t r, adcdc_hist_t h);
        logic in_band;
        logic entered;
        in_band = (r == mode_target(m));
        entered = (h.region != r);
        return in_band && (!mode_entry(m) || entered) && (!mode_hyst(m) || h.armed);
    endfunction

    // Arming follows the opposite band; entry modes disarm on output,
    // each modes disarm when the run of in-band results ends
    function automatic adcdc_hist_t hist_advance(adcdc_mode_t m, adcdc_region_t r,
                                                adcdc_hist_t h, logic fire);
        adcdc_hist_t n;
        n.region = r;
        n.armed  = h.armed;
        if (r == mode_opposite(m)) begin
            n.armed = 1'b1;
        end else if (!mode_hyst(m)) begin
            n.armed = 1'b0;
        end else if (fire && mode_entry(m)) begin
            n.armed = 1'b0;
        end else if (h.region == mode_target(m) && r != mode_target(m)) begin
            n.armed = 1'b0;
        end
        return n;
    endfunction

    localparam adcdc_hist_t HIST_INIT = '{region: REG_NONE, armed: 1'b0};

    // ****************************************************************
    // State
    // ****************************************************************
    adcdc_cfg_t                 cfg_reg       [NUM_COMP];
    adcdc_thr_t                 thr_reg       [NUM_COMP];
    adcdc_hist_t                trig_hist_reg [NUM_COMP];
    adcdc_hist_t                irq_hist_reg  [NUM_COMP];
    adcdc_hist_t                trig_hist_next[NUM_COMP];
    adcdc_hist_t                irq_hist_next [NUM_COMP];
    logic [NUM_COMP-1:0]        fault_reg;
    logic [NUM_COMP-1:0]        fault_next;
    logic [NUM_COMP-1:0]        irq_hit;
    logic [NUM_COMP-1:0]        comp_status_reg;
    logic [NUM_COMP-1:0]        comp_status_next;
    logic [`ADCDC_NUM_SEQ-1:0]  seq_en_reg;
    logic [`ADCDC_NUM_SEQ-1:0]  seq_status_reg;
    logic [`ADCDC_NUM_SEQ-1:0]  seq_status_next;
    logic [31:0]                prdata_reg;
    logic                       pslverr_reg;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire logic                  setup_ph   = psel && !penable;
    wire logic                  wr_en      = psel && penable && pwrite;
    wire logic [11:0]           cmp_off    = paddr - `ADCDC_OFF_CMP_BASE;
    wire logic [11:0]           cmp_span   = 12'(NUM_COMP << `ADCDC_CMP_STRIDE_SH);
    wire logic                  in_cmp     = (paddr >= `ADCDC_OFF_CMP_BASE) &&
                                             (cmp_off < cmp_span) && (paddr[1:0] == 2'h0);
    wire logic [`ADCDC_IDX_W-1:0] cmp_idx  = cmp_off[`ADCDC_CMP_STRIDE_SH +: `ADCDC_IDX_W];
    wire logic                  cmp_thr    = paddr[`ADCDC_CMP_LANE_BIT];
    wire logic                  hit_status = (paddr == `ADCDC_OFF_STATUS);
    wire logic                  hit_clear  = (paddr == `ADCDC_OFF_CLEAR);
    wire logic                  hit_seq_en = (paddr == `ADCDC_OFF_SEQ_EN);
    wire logic                  hit_seq_st = (paddr == `ADCDC_OFF_SEQ_STAT);
    wire logic                  hit_seq_cl = (paddr == `ADCDC_OFF_SEQ_CLR);
    wire logic                  hit_hist   = (paddr == `ADCDC_OFF_HIST_RST);
    wire logic                  mapped     = hit_status || hit_clear || hit_seq_en ||
                                             hit_seq_st || hit_seq_cl || hit_hist || in_cmp;

    wire logic [NUM_COMP-1:0]   clr_mask   = (wr_en && hit_clear) ?
                                             pwdata[NUM_COMP-1:0] : '0;
    wire logic [`ADCDC_NUM_SEQ-1:0] seq_clr = (wr_en && hit_seq_cl) ?
                                             pwdata[`ADCDC_NUM_SEQ-1:0] : '0;
    wire logic [NUM_COMP-1:0]   rst_trig   = (wr_en && hit_hist) ?
                                             pwdata[NUM_COMP-1:0] : '0;
    wire logic [NUM_COMP-1:0]   rst_irq    = (wr_en && hit_hist) ?
                                             pwdata[`ADCDC_RST_IRQ_LSB +: NUM_COMP] : '0;

    // Write-only and clear registers read back as zero
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_status) begin
            rd_word[NUM_COMP-1:0] = comp_status_reg;
        end else if (hit_seq_en) begin
            rd_word[`ADCDC_NUM_SEQ-1:0] = seq_en_reg;
        end else if (hit_seq_st) begin
            rd_word[`ADCDC_NUM_SEQ-1:0] = seq_status_reg;
        end else if (in_cmp && !cmp_thr) begin
            rd_word[`ADCDC_CFG_FAULT_LSB +: `ADCDC_MODE_W] = cfg_reg[cmp_idx].fault_mode;
            rd_word[`ADCDC_CFG_IRQ_LSB +: `ADCDC_MODE_W]   = cfg_reg[cmp_idx].irq_mode;
        end else if (in_cmp) begin
            rd_word[`ADCDC_THR_LO_LSB +: `ADCDC_DATA_W] = thr_reg[cmp_idx].lower_threshold;
            rd_word[`ADCDC_THR_HI_LSB +: `ADCDC_DATA_W] = thr_reg[cmp_idx].upper_threshold;
        end
    end

    // ****************************************************************
    // Comparator evaluation
    // ****************************************************************
    // Only one result arrives per cycle, so one classifier serves all
    wire logic          res_ok     = res_valid && (32'(res_data.comp) < NUM_COMP);
    wire adcdc_region_t cur_region = classify(res_data.value, thr_reg[res_data.comp]);

    always_comb begin
        for (int i = 0; i < NUM_COMP; i++) begin
            trig_hist_next[i] = trig_hist_reg[i];
            irq_hist_next[i]  = irq_hist_reg[i];
            fault_next[i]     = 1'b0;
            irq_hit[i]        = 1'b0;
            if (res_ok && res_data.comp == `ADCDC_IDX_W'(i)) begin
                // Fault and interrupt sides keep separate history
                fault_next[i] = mode_fires(cfg_reg[i].fault_mode, cur_region,
                                           trig_hist_reg[i]);
                irq_hit[i]    = mode_fires(cfg_reg[i].irq_mode, cur_region,
                                           irq_hist_reg[i]);
                trig_hist_next[i] = hist_advance(cfg_reg[i].fault_mode, cur_region,
                                                 trig_hist_reg[i], fault_next[i]);
                irq_hist_next[i]  = hist_advance(cfg_reg[i].irq_mode, cur_region,
                                                 irq_hist_reg[i], irq_hit[i]);
            end
            // A software reset beats a result in the same cycle
            if (rst_trig[i]) begin
                trig_hist_next[i] = HIST_INIT;
            end
            if (rst_irq[i]) begin
                irq_hist_next[i] = HIST_INIT;
            end
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    // Set wins over a clear landing in the same cycle
    assign comp_status_next = (comp_status_reg & ~clr_mask) | irq_hit;
    assign seq_status_next  = (seq_status_reg & ~seq_clr) |
                              ((|irq_hit) ? `ADCDC_NUM_SEQ'(1) << res_data.seq
                                          : '0);

    assign compare_irq_seq  = seq_status_reg & seq_en_reg;
    assign irq              = |compare_irq_seq;
    assign fault_trigger    = fault_reg;
    assign prdata           = prdata_reg;
    assign pslverr          = pslverr_reg;
    // Zero wait states: read data is captured in the setup cycle
    assign pready           = 1'b1;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_COMP; i++) begin
                cfg_reg[i]       <= '0;
                thr_reg[i]       <= '0;
                trig_hist_reg[i] <= HIST_INIT;
                irq_hist_reg[i]  <= HIST_INIT;
            end
        end else begin
            for (int i = 0; i < NUM_COMP; i++) begin
                trig_hist_reg[i] <= trig_hist_next[i];
                irq_hist_reg[i]  <= irq_hist_next[i];
            end
            if (wr_en && in_cmp && !cmp_thr) begin
                cfg_reg[cmp_idx].fault_mode <=
                    pwdata[`ADCDC_CFG_FAULT_LSB +: `ADCDC_MODE_W];
                cfg_reg[cmp_idx].irq_mode   <=
                    pwdata[`ADCDC_CFG_IRQ_LSB +: `ADCDC_MODE_W];
            end
            if (wr_en && in_cmp && cmp_thr) begin
                thr_reg[cmp_idx].lower_threshold <=
                    pwdata[`ADCDC_THR_LO_LSB +: `ADCDC_DATA_W];
                thr_reg[cmp_idx].upper_threshold <=
                    pwdata[`ADCDC_THR_HI_LSB +: `ADCDC_DATA_W];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_reg       <= '0;
            comp_status_reg <= '0;
            seq_status_reg  <= '0;
            seq_en_reg      <= '0;
        end else begin
            fault_reg       <= fault_next;
            comp_status_reg <= comp_status_next;
            seq_status_reg  <= seq_status_next;
            if (wr_en && hit_seq_en) begin
                seq_en_reg <= pwdata[`ADCDC_NUM_SEQ-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr_reg <= !mapped;
        end
    end

endmodule

// ---- shared/adcdc_cfg.svh ----
`ifndef ADCDC_CFG_SVH
`define ADCDC_CFG_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define ADCDC_DATA_W        12
`define ADCDC_IDX_W         3
`define ADCDC_SEQ_W         2
`define ADCDC_NUM_SEQ       4
`define ADCDC_MODE_W        4

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define ADCDC_OFF_STATUS    12'h000
`define ADCDC_OFF_CLEAR     12'h004
`define ADCDC_OFF_SEQ_EN    12'h008
`define ADCDC_OFF_SEQ_STAT  12'h00C
`define ADCDC_OFF_SEQ_CLR   12'h010
`define ADCDC_OFF_HIST_RST  12'h014
`define ADCDC_OFF_CMP_BASE  12'h040
`define ADCDC_CMP_STRIDE_SH 3
`define ADCDC_CMP_LANE_BIT  2

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCDC_CFG_FAULT_LSB 0
`define ADCDC_CFG_IRQ_LSB   8
`define ADCDC_THR_LO_LSB    0
`define ADCDC_THR_HI_LSB    16
`define ADCDC_RST_IRQ_LSB   16

// ****************************************************************
// Mode codes
// ****************************************************************
`define ADCDC_M_OFF          4'h0
`define ADCDC_M_LOW_EACH     4'h1
`define ADCDC_M_LOW_ENTRY    4'h2
`define ADCDC_M_LOW_EACH_H   4'h3
`define ADCDC_M_LOW_ENTRY_H  4'h4
`define ADCDC_M_MID_EACH     4'h5
`define ADCDC_M_MID_ENTRY    4'h6
`define ADCDC_M_HIGH_EACH    4'h7
`define ADCDC_M_HIGH_ENTRY   4'h8
`define ADCDC_M_HIGH_EACH_H  4'h9
`define ADCDC_M_HIGH_ENTRY_H 4'hA

`endif

// ---- shared/adcdc_pkg.sv ----
`include "adcdc_cfg.svh"

package adcdc_pkg;

    typedef logic [`ADCDC_MODE_W-1:0] adcdc_mode_t;

    typedef enum logic [1:0] {
        REG_NONE,
        REG_LOW,
        REG_MID,
        REG_HIGH
    } adcdc_region_t;

    typedef struct packed {
        logic [`ADCDC_DATA_W-1:0] value;
        logic [`ADCDC_SEQ_W-1:0]  seq;
        logic [`ADCDC_IDX_W-1:0]  comp;
    } adcdc_result_t;

    typedef struct packed {
        adcdc_mode_t irq_mode;
        adcdc_mode_t fault_mode;
    } adcdc_cfg_t;

    typedef struct packed {
        logic [`ADCDC_DATA_W-1:0] upper_threshold;
        logic [`ADCDC_DATA_W-1:0] lower_threshold;
    } adcdc_thr_t;

    typedef struct packed {
        adcdc_region_t region;
        logic          armed;
    } adcdc_hist_t;

endpackage

// ---- sim/adcdc_core_sva.sv ----
`timescale 1ns/1ps
`include "adcdc_cfg.svh"
// ****************************************************************
// Port checker
// ****************************************************************
module adcdc_core_sva #(
    parameter int NUM_COMP = 8
) (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic                      pslverr,
    input wire logic                      res_valid,
    input wire adcdc_pkg::adcdc_result_t  res_data,
    input wire logic [NUM_COMP-1:0]       fault_trigger,
    input wire logic [`ADCDC_NUM_SEQ-1:0] compare_irq_seq,
    input wire logic                      irq
);
    import adcdc_pkg::*;
    wire wr_acc = psel && penable && pwrite;
    wire acc    = psel && penable;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_irq_seq_or: assert property (irq == (|compare_irq_seq))
        else $error("irq differs from OR of sequence lines");
    a_fault_from_result: assert property (fault_trigger != '0 |-> $past(res_valid)
        && fault_trigger == (NUM_COMP'(1) << $past(res_data.comp)))
        else $error("fault pulse without matching result");
    a_fault_needs_result: assert property (!res_valid |=> fault_trigger == '0)
        else $error("fault pulse with no result taken");
    a_irq_rise_cause: assert property ($rose(irq) |-> $past(res_valid) || $past(wr_acc))
        else $error("irq rose without result or write");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_acc))
        else $error("irq fell without a write");
    a_seq_irq_hold: assert property (!res_valid && !wr_acc |=> $stable(compare_irq_seq))
        else $error("sequence irq changed with no cause");
    a_unmapped_err: assert property (acc && (paddr[1:0] != 2'h0
        || paddr inside {[12'h018:12'h03F]}) |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (acc && paddr inside {[12'h000:12'h014]}
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access flagged as error");
endmodule

bind adcdc_core adcdc_core_sva #(
    .NUM_COMP(NUM_COMP)
) i_adcdc_core_sva (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pslverr(pslverr), .res_valid(res_valid), .res_data(res_data),
    .fault_trigger(fault_trigger), .compare_irq_seq(compare_irq_seq), .irq(irq)
);

// ---- sim/adcdc_seq_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Sequencer result source and fault input counter
// ****************************************************************
module adcdc_seq_model #(
    parameter int NUM_COMP = 8
) (
    input  wire logic                clk,
    output logic                     res_valid,
    output adcdc_pkg::adcdc_result_t res_data,
    input  wire logic [NUM_COMP-1:0] fault_trigger
);
    import adcdc_pkg::*;
    int pulses = 0;
    initial begin
        res_valid = 1'b0;
        res_data = '0;
    end
    // Counts high cycles, so a pulse wider than one cycle inflates the total
    always @(posedge clk) begin
        if (fault_trigger != '0) begin
            pulses <= pulses + 1;
        end
    end
    task automatic send(input logic [11:0] v, input logic [1:0] s, input logic [2:0] c,
                        output logic [NUM_COMP-1:0] f);
        @(posedge clk);
        res_valid <= 1'b1;
        res_data  <= '{value: v, seq: s, comp: c};
        @(posedge clk);
        res_valid <= 1'b0;
        // Idle bus shows the inverse so stale data never looks valid
        res_data  <= adcdc_result_t'(~{v, s, c});
        #1;
        f = fault_trigger;
    endtask
endmodule

// ---- sim/test_adcdc_core.sv ----
`timescale 1ns/1ps
`include "adcdc_cfg.svh"
// ****************************************************************
// Bench top
// ****************************************************************
module test_adcdc_core;
    import adcdc_pkg::*;
    localparam int NC = 8;
    logic          clk;
    logic          rst_n;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          res_valid;
    adcdc_result_t res_data;
    logic [NC-1:0] fault_trigger;
    logic [3:0]    compare_irq_seq;
    logic          irq;
    int            err_count = 0;
    int            tests_run = 0;
    int            fires = 0;
    logic [31:0]   rdat;
    logic          rerr;

    adcdc_core #(.NUM_COMP(NC)) i_adcdc_core (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .res_valid(res_valid), .res_data(res_data),
        .fault_trigger(fault_trigger), .compare_irq_seq(compare_irq_seq), .irq(irq)
    );
    adcdc_seq_model #(.NUM_COMP(NC)) i_adcdc_seq_model (
        .clk(clk), .res_valid(res_valid), .res_data(res_data),
        .fault_trigger(fault_trigger)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bounded wait on pready, at most 20 cycles; this slave ties pready high and never answers late
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            stop_test();
        end
        #1;
    endtask

    function automatic int band(input logic [11:0] v);
        return (v <= 12'h064) ? 1 : (v <= 12'h0C8) ? 2 : 3;
    endfunction

    task automatic setup(input logic [2:0] c, input logic [3:0] fm, input logic [3:0] im);
        apb(1'b1, `ADCDC_OFF_CMP_BASE + {6'h0, c, 3'h0}, {20'h0, im, 4'h0, fm});
        apb(1'b1, `ADCDC_OFF_CMP_BASE + {6'h0, c, 3'h4}, {4'h0, 12'h0C8, 4'h0, 12'h064});
    endtask

    // One result, then fault pulse and status word are judged and cleared
    task automatic step(input logic [2:0] c, input logic [11:0] v, input bit ef, input bit ei);
        logic [NC-1:0] f;
        i_adcdc_seq_model.send(v, c[1:0], c, f);
        check_word("fault", ef ? 32'h1 << c : 32'h0, 32'(f));
        fires += ef;
        apb(1'b0, `ADCDC_OFF_STATUS, 32'h0);
        check_word("status", ei ? 32'h1 << c : 32'h0, rdat);
        apb(1'b1, `ADCDC_OFF_CLEAR, 32'hFF);
    endtask

    task automatic play(input logic [2:0] c, input logic [3:0] fm, input logic [3:0] im,
                        input logic [11:0] v [6], input bit ef [6], input bit ei [6]);
        setup(c, fm, im);
        for (int i = 0; i < 6; i++) begin
            step(c, v[i], ef[i], ei[i]);
        end
    endtask

    task automatic t_reset();
        apb(1'b0, `ADCDC_OFF_CMP_BASE, 32'h0);
        check_word("config", 32'h0, rdat);
        check_word("config error", 32'h0, {31'h0, rerr});
        apb(1'b0, `ADCDC_OFF_SEQ_EN, 32'h0);
        check_word("seq enable", 32'h0, rdat);
        apb(1'b0, 12'h018, 32'h0);
        check_word("unmapped error", 32'h1, {31'h0, rerr});
        check_word("irq", 32'h0, {31'h0, irq});
        $display("reset test done");
    endtask

    task automatic t_each();
        logic [3:0]  m [4];
        logic [11:0] v [6];
        bit          ef [6];
        bit          z [6];
        m = '{`ADCDC_M_OFF, `ADCDC_M_LOW_EACH, `ADCDC_M_MID_EACH, `ADCDC_M_HIGH_EACH};
        v = '{12'h064, 12'h065, 12'h0C8, 12'h0C9, 12'h064, 12'h0C9};
        z = '{0, 0, 0, 0, 0, 0};
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 6; i++) begin
                ef[i] = (k != 0) && (band(v[i]) == k);
            end
            play(3'h0, m[k], `ADCDC_M_OFF, v, ef, z);
            play(3'h5, `ADCDC_M_OFF, m[k], v, z, ef);
        end
        // Codes past the last mode act as off
        play(3'h7, 4'hB, 4'hB, v, z, z);
        $display("each mode test done");
    endtask

    task automatic t_modes();
        play(3'h1, `ADCDC_M_MID_ENTRY, `ADCDC_M_HIGH_ENTRY,
             '{12'h032, 12'h096, 12'h0A0, 12'h0FA, 12'h0FA, 12'h096},
             '{0, 1, 0, 0, 0, 1}, '{0, 0, 0, 1, 0, 0});
        play(3'h2, `ADCDC_M_HIGH_EACH_H, `ADCDC_M_LOW_ENTRY_H,
             '{12'h0FA, 12'h032, 12'h0FA, 12'h0FA, 12'h096, 12'h0FA},
             '{0, 0, 1, 1, 0, 0}, '{0, 1, 0, 0, 0, 0});
        play(3'h3, `ADCDC_M_LOW_EACH_H, `ADCDC_M_HIGH_ENTRY_H,
             '{12'h032, 12'h0FA, 12'h032, 12'h032, 12'h096, 12'h0FA},
             '{0, 0, 1, 1, 0, 0}, '{0, 1, 0, 0, 0, 1});
        // Low entry on both sides: first result counts as entry after reset
        play(3'h6, `ADCDC_M_LOW_ENTRY, `ADCDC_M_LOW_ENTRY,
             '{12'h032, 12'h032, 12'h096, 12'h032, 12'h0FA, 12'h032},
             '{1, 0, 0, 1, 0, 1}, '{1, 0, 0, 1, 0, 1});
        step(3'h1, 12'h096, 1'b0, 1'b0);
        apb(1'b1, `ADCDC_OFF_HIST_RST, 32'h0000_0002);
        step(3'h1, 12'h096, 1'b1, 1'b0);
        step(3'h1, 12'h0FA, 1'b0, 1'b1);
        apb(1'b1, `ADCDC_OFF_HIST_RST, 32'h0002_0000);
        step(3'h1, 12'h0FA, 1'b0, 1'b1);
        $display("entry and hysteresis test done");
    endtask

    task automatic t_irq();
        logic [NC-1:0] f;
        apb(1'b1, `ADCDC_OFF_SEQ_CLR, 32'hF);
        setup(3'h4, `ADCDC_M_OFF, `ADCDC_M_LOW_EACH);
        setup(3'h6, `ADCDC_M_OFF, `ADCDC_M_LOW_EACH);
        i_adcdc_seq_model.send(12'h032, 2'h2, 3'h4, f);
        i_adcdc_seq_model.send(12'h032, 2'h0, 3'h6, f);
        apb(1'b0, `ADCDC_OFF_STATUS, 32'h0);
        check_word("status", 32'h50, rdat);
        apb(1'b0, `ADCDC_OFF_SEQ_STAT, 32'h0);
        check_word("sequence status", 32'h5, rdat);
        check_word("irq", 32'h0, {31'h0, irq});
        apb(1'b1, `ADCDC_OFF_SEQ_EN, 32'h4);
        check_word("sequence irq", 32'h4, {28'h0, compare_irq_seq});
        check_word("irq", 32'h1, {31'h0, irq});
        apb(1'b1, `ADCDC_OFF_CLEAR, 32'h10);
        apb(1'b1, `ADCDC_OFF_STATUS, 32'h0);
        apb(1'b0, `ADCDC_OFF_STATUS, 32'h0);
        check_word("status", 32'h40, rdat);
        apb(1'b1, `ADCDC_OFF_SEQ_EN, 32'h5);
        apb(1'b1, `ADCDC_OFF_SEQ_CLR, 32'h4);
        check_word("sequence irq", 32'h1, {28'h0, compare_irq_seq});
        apb(1'b1, `ADCDC_OFF_SEQ_EN, 32'h4);
        check_word("irq", 32'h0, {31'h0, irq});
        $display("interrupt test done");
    endtask

    initial begin
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_each();
        t_modes();
        t_irq();
        check_word("fault pulses", fires, i_adcdc_seq_model.pulses);
        stop_test();
    end
endmodule
